// *** hw/dbl_pkg.sv ***
// Package: pin codes, modes and timing for the DAC latch host controller
package dbl_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CODE_W   = 12;
  localparam int NIB_W    = 4;
  localparam int BYTE_W   = 8;
  localparam int MSB_POS  = 11;
  // ----------------------------------------------------------------
  // Latch-select patterns {second, high, mid, low}, active low
  // ----------------------------------------------------------------
  localparam logic [3:0] SEL_IDLE  = 4'hf;
  localparam logic [3:0] SEL_LOW   = 4'he;
  localparam logic [3:0] SEL_MID   = 4'hd;
  localparam logic [3:0] SEL_HIGH  = 4'hb;
  localparam logic [3:0] SEL_XFER  = 4'h7;
  localparam logic [3:0] SEL_ALL   = 4'h0;
  // ----------------------------------------------------------------
  // Bus mapping modes and coding
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MAP_NIBBLE, MAP_LEFT8, MAP_RIGHT8, MAP_WORD
  } dbl_map_t;
  localparam logic [1:0] ADDR_FIRST  = 2'h1;
  localparam logic [1:0] ADDR_SECOND = 2'h2;
  // ----------------------------------------------------------------
  // Timing: strobe low width and setup time, in ns
  // ----------------------------------------------------------------
  localparam int CLK_NS    = 10;
  localparam int STROBE_NS = 100;
  localparam int SETUP_NS  = 30;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_CYC  = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W      = 8;
endpackage

// *** hw/dbl_strobe.sv ***
// Strobe timer: setup, active-low strobe, hold phases of one bus step
`timescale 1ns/1ps
module dbl_strobe
  import dbl_pkg::*;
#(
  parameter int SETUP  = SETUP_CYC,
  parameter int STROBE = STROBE_CYC
) (
  input  wire logic core_clk,
  input  wire logic arst_n,
  input  wire logic clk_en,
  input  wire logic go,
  output logic      strobe_on,
  output logic      done
);
  import dbl_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_LOW, ST_HOLD} dbl_ph_t;
  dbl_ph_t          ph_q, ph_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             done_d, on_d;

  // ----------------------------------------------------------------
  // Phase sequencing
  // ----------------------------------------------------------------
  always_comb begin
    ph_d   = ph_q;
    cnt_d  = cnt_q;
    done_d = 1'b0;
    on_d   = 1'b0;
    case (ph_q)
      ST_IDLE: begin
        if (go) begin
          ph_d  = ST_SETUP;
          cnt_d = CNT_W'(SETUP);
        end
      end
      ST_SETUP: begin
        if (cnt_q <= CNT_W'(1)) begin
          ph_d  = ST_LOW;
          cnt_d = CNT_W'(STROBE);
          on_d  = 1'b1;
        end else begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end
      ST_LOW: begin
        on_d = 1'b1;
        if (cnt_q <= CNT_W'(1)) begin
          ph_d = ST_HOLD;
          on_d = 1'b0;
        end else begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end
      ST_HOLD: begin
        // One idle cycle keeps data steady after strobe rises
        ph_d   = ST_IDLE;
        done_d = 1'b1;
      end
      default: ph_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ph_q      <= ST_IDLE;
      cnt_q     <= '0;
      done      <= 1'b0;
      strobe_on <= 1'b0;
    end else if (clk_en) begin
      ph_q      <= ph_d;
      cnt_q     <= cnt_d;
      done      <= done_d;
      strobe_on <= on_d;
    end
  end
endmodule

// *** hw/dbl_host.sv ***
// Host controller that loads a 12-bit DAC through its two latch ranks
`timescale 1ns/1ps
module dbl_host
  import dbl_pkg::*;
#(
  parameter int SETUP  = SETUP_CYC,
  parameter int STROBE = STROBE_CYC
) (
  input  wire logic              core_clk,
  input  wire logic              arst_n,
  input  wire logic              clk_en,
  input  wire logic              req_valid,
  input  wire logic [CODE_W-1:0] req_code,
  input  wire logic              req_twos,
  input  wire dbl_pkg::dbl_map_t req_map,
  output logic                   req_ready,
  output logic                   req_done,
  output logic                   chip_sel_n,
  output logic                   low_nibble_latch_sel_n,
  output logic                   mid_nibble_latch_sel_n,
  output logic                   high_nibble_latch_sel_n,
  output logic                   second_rank_load_n,
  output logic [CODE_W-1:0]      data_in,
  output logic [1:0]             bus_addr
);
  import dbl_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE, S_STEP1, S_STEP2, S_STEP3, S_STEP4, S_DONE
  } dbl_st_t;

  dbl_st_t           st_q, st_d;
  logic [CODE_W-1:0] code_q, code_d;
  dbl_map_t          map_q, map_d;
  logic [3:0]        sel_q, sel_d;
  logic              cs_q, cs_d;
  logic [CODE_W-1:0] bus_q, bus_d;
  logic [1:0]        addr_q, addr_d;
  logic              rdy_q, rdy_d;
  logic              done_q, done_d;
  logic              go;
  logic              strobe_on;
  logic              step_done;

  // Lays out the pins for one step of a given mapping
  function automatic logic [CODE_W-1:0] bus_word(
    input dbl_map_t m, input logic [CODE_W-1:0] c, input logic second);
    logic [CODE_W-1:0] w;
    w = '0;
    case (m)
      MAP_LEFT8:
        // Second byte: eight MSBs; first byte: low nibble in upper half
        w = second ? {4'h0, c[11:4]} : {4'h0, c[3:0], 4'h0};
      MAP_RIGHT8:
        w = second ? {8'h00, c[11:8]} : {4'h0, c[7:0]};
      default: w = c;
    endcase
    return w;
  endfunction

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_d   = st_q;
    code_d = code_q;
    map_d  = map_q;
    sel_d  = sel_q;
    cs_d   = cs_q;
    bus_d  = bus_q;
    addr_d = addr_q;
    rdy_d  = 1'b0;
    done_d = 1'b0;
    go     = 1'b0;
    case (st_q)
      S_IDLE: begin
        rdy_d = 1'b1;
        cs_d  = 1'b1;
        sel_d = SEL_IDLE;
        if (req_valid && rdy_q) begin
          // Inverting MSB turns two's complement into offset binary
          code_d = req_code ^ {req_twos, {MSB_POS{1'b0}}};
          map_d  = req_map;
          rdy_d  = 1'b0;
          go     = 1'b1;
          st_d   = S_STEP1;
          if (req_map == MAP_NIBBLE) begin
            // Drive the full word; each nibble strobe takes its slice
            bus_d = code_d;
          end else begin
            bus_d = bus_word(req_map, code_d, 1'b0);
          end
          addr_d = (req_map == MAP_LEFT8 || req_map == MAP_RIGHT8) ?
                   ADDR_FIRST : 2'h0;
        end
      end
      S_STEP1, S_STEP2, S_STEP3, S_STEP4: begin
        // Data is already on the bus one setup time before strobe
        cs_d = ~strobe_on;
        case (map_q)
          MAP_NIBBLE: sel_d = (st_q == S_STEP1) ? SEL_LOW :
                              (st_q == S_STEP2) ? SEL_MID :
                              (st_q == S_STEP3) ? SEL_HIGH :
                              SEL_XFER;
          // Left: X01 low nibble; X10 high+mid nibbles with update
          MAP_LEFT8:  sel_d = (st_q == S_STEP1) ? SEL_LOW :
                              (SEL_MID & SEL_HIGH & SEL_XFER);
          // Right: X01 low+mid nibbles; X10 high nibble with update
          MAP_RIGHT8: sel_d = (st_q == S_STEP1) ? (SEL_LOW & SEL_MID) :
                              (SEL_HIGH & SEL_XFER);
          default:    sel_d = SEL_ALL;
        endcase
        if (!strobe_on) sel_d = SEL_IDLE;
        if (step_done) begin
          // Bus changes only after the strobe has risen
          if ((map_q == MAP_NIBBLE && st_q != S_STEP4) ||
              ((map_q == MAP_LEFT8 || map_q == MAP_RIGHT8) &&
               st_q == S_STEP1)) begin
            go   = 1'b1;
            st_d = dbl_st_t'(st_q + 3'h1);
            if (map_q != MAP_NIBBLE) begin
              bus_d  = bus_word(map_q, code_q, 1'b1);
              addr_d = ADDR_SECOND;
            end
          end else begin
            st_d = S_DONE;
          end
        end
      end
      S_DONE: begin
        // Word mode: bus stays steady until chip select is high
        done_d = 1'b1;
        st_d   = S_IDLE;
      end
      default: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q   <= S_IDLE;
      code_q <= '0;
      map_q  <= MAP_NIBBLE;
      sel_q  <= SEL_IDLE;
      cs_q   <= 1'b1;
      bus_q  <= '0;
      addr_q <= '0;
      rdy_q  <= 1'b0;
      done_q <= 1'b0;
    end else if (clk_en) begin
      st_q   <= st_d;
      code_q <= code_d;
      map_q  <= map_d;
      sel_q  <= sel_d;
      cs_q   <= cs_d;
      bus_q  <= bus_d;
      addr_q <= addr_d;
      rdy_q  <= rdy_d;
      done_q <= done_d;
    end
  end

  // ----------------------------------------------------------------
  // Strobe timing
  // ----------------------------------------------------------------
  dbl_strobe #(
    .SETUP  (SETUP),
    .STROBE (STROBE)
  ) u_strobe (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .clk_en    (clk_en),
    .go        (go),
    .strobe_on (strobe_on),
    .done      (step_done)
  );

  assign req_ready               = rdy_q;
  assign req_done                = done_q;
  assign chip_sel_n              = cs_q;
  assign low_nibble_latch_sel_n  = sel_q[0];
  assign mid_nibble_latch_sel_n  = sel_q[1];
  assign high_nibble_latch_sel_n = sel_q[2];
  assign second_rank_load_n      = sel_q[3];
  assign data_in                 = bus_q;
  assign bus_addr                = addr_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_idle_no_enable: assert property (@(posedge core_clk) disable iff (!arst_n)
    (st_q == S_IDLE) |-> (cs_q && sel_q == SEL_IDLE))
    else $error("idle state drives an enable");
  a_data_stable_sel: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    (!cs_q && $past(!cs_q)) |-> $stable(bus_q))
    else $error("data moved while chip select low");
  a_word_all_low: assert property (@(posedge core_clk) disable iff (!arst_n)
    (!cs_q && map_q == MAP_WORD) |-> sel_q == SEL_ALL)
    else $error("word mode select not all low");
  a_nibble_low_first: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    (!cs_q && map_q == MAP_NIBBLE && st_q == S_STEP1)
      |-> sel_q == SEL_LOW)
    else $error("first nibble step not low select");
  a_sel_with_cs: assert property (@(posedge core_clk) disable iff (!arst_n)
    (sel_q != SEL_IDLE) |-> !cs_q)
    else $error("select active without chip select");
  a_left_second: assert property (@(posedge core_clk) disable iff (!arst_n)
    (!cs_q && map_q == MAP_LEFT8 && addr_q == ADDR_SECOND)
      |-> (sel_q == 4'h1 && bus_q == {4'h0, code_q[11:4]}))
    else $error("left second byte wrong");
  a_right_first: assert property (@(posedge core_clk) disable iff (!arst_n)
    (!cs_q && map_q == MAP_RIGHT8 && addr_q == ADDR_FIRST)
      |-> (sel_q == 4'hc && bus_q == {4'h0, code_q[7:0]}))
    else $error("right first byte wrong");
  a_twos_msb: assert property (@(posedge core_clk) disable iff (!arst_n)
    (st_q == S_IDLE && req_valid && rdy_q && clk_en) |=>
      code_q[MSB_POS] == ($past(req_code[MSB_POS]) ^ $past(req_twos)))
    else $error("MSB inversion wrong");
endmodule

// *** sim/dbl_dac_model.sv ***
// Behavioural model of the converter's two-rank input latches
`timescale 1ns/1ps
module dbl_dac_model (
  input  wire logic        cs_n,
  input  wire logic [3:0]  sel_n,
  input  wire logic [11:0] db,
  output logic [11:0]      code
);
  logic [11:0] rank1;
  logic [11:0] dv;
  logic [3:0]  en;

  // ----------------------------------------------------------------
  // Pin decode
  // ----------------------------------------------------------------
  // Open or unknown pins read as low, so a floating select enables
  always_comb begin
    for (int i = 0; i < 12; i++)
      dv[i] = (db[i] === 1'b1);
    for (int i = 0; i < 4; i++)
      en[i] = (cs_n !== 1'b1) && (sel_n[i] !== 1'b1);
  end

  // ----------------------------------------------------------------
  // Latches
  // ----------------------------------------------------------------
  // Level-sensitive first rank, three independent nibbles
  always_latch begin
    if (en[0])
      rank1[3:0] <= dv[3:0];
    if (en[1])
      rank1[7:4] <= dv[7:4];
    if (en[2])
      rank1[11:8] <= dv[11:8];
  end

  // Second rank follows first rank, so both open means flow-through
  always_latch begin
    if (en[3])
      code <= rank1;
  end
endmodule

// *** sim/tb_dac_double_buffer_latches.sv ***
// Self-checking bench for the converter latch host controller
`timescale 1ns/1ps
module tb_dac_double_buffer_latches;
  import dbl_pkg::*;
  logic        core_clk  = 1'b0;
  logic        arst_n    = 1'b0;
  logic        clk_en    = 1'b1;
  logic        req_valid = 1'b0;
  logic        req_twos  = 1'b0;
  logic [11:0] req_code  = 12'h000;
  dbl_map_t    req_map   = MAP_NIBBLE;
  dbl_map_t    cur_map   = MAP_NIBBLE;
  logic        req_ready, req_done, chip_sel_n, was_low;
  logic        lo_n, mid_n, hi_n, sec_n;
  logic [11:0] data_in, db, dac, held, last;
  logic [11:0] ex;
  logic [1:0]  bus_addr;
  logic [3:0]  sel;
  logic [3:0]  ex_s;
  logic [1:0]  ex_a;
  int          stp = 0;
  logic [11:0] q[$];
  int          checks = 0;
  int          fails  = 0;

  always #5 core_clk = ~core_clk;
  assign sel = {sec_n, hi_n, mid_n, lo_n};

  dbl_host #(.SETUP(1), .STROBE(2)) DUT (
    .core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en),
    .req_valid(req_valid), .req_code(req_code), .req_twos(req_twos),
    .req_map(req_map), .req_ready(req_ready), .req_done(req_done),
    .chip_sel_n(chip_sel_n), .low_nibble_latch_sel_n(lo_n),
    .mid_nibble_latch_sel_n(mid_n), .high_nibble_latch_sel_n(hi_n),
    .second_rank_load_n(sec_n), .data_in(data_in), .bus_addr(bus_addr));

  dbl_dac_model u_dac (.cs_n(chip_sel_n), .sel_n(sel), .db(db), .code(dac));

  // ----------------------------------------------------------------
  // Board wiring of the byte bus onto the converter pins
  // ----------------------------------------------------------------
  // Byte modes overlap data lines, as a real board would
  always_comb begin
    case (cur_map)
      MAP_LEFT8:  db = {data_in[7:0], data_in[7:4]};
      MAP_RIGHT8: db = {data_in[3:0], data_in[7:0]};
      default:    db = data_in;
    endcase
  end

  // Expected selects for step k (counted from 1) of a transfer in map m
  function automatic logic [3:0] exp_sel(dbl_map_t m, int k);
    case (m)
      MAP_NIBBLE: return (k == 1) ? SEL_LOW : (k == 2) ? SEL_MID :
                         (k == 3) ? SEL_HIGH : SEL_XFER;
      MAP_LEFT8:  return (k == 1) ? SEL_LOW : 4'h1;
      MAP_RIGHT8: return (k == 1) ? 4'hc : 4'h3;
      default:    return SEL_ALL;
    endcase
  endfunction

  task automatic chk(logic [11:0] seen, logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Stall the controller now and then, to exercise the freeze path
  always @(posedge core_clk) begin
    #1;
    clk_en = ($urandom % 8) != 0;
  end

  // Valid stays up between sends, so back-to-back requests are taken
  task automatic send(dbl_map_t m, logic [11:0] c, logic t);
    logic hit;
    req_map = m;
    req_code = c;
    req_twos = t;
    req_valid = 1'b1;
    hit = 1'b0;
    for (int n = 0; n < 4000 && !hit; n++) begin
      @(negedge core_clk);
      hit = req_ready & clk_en;
      @(posedge core_clk);
      #1;
    end
    if (!hit) begin
      fails++;
      end_of_test();
    end
    cur_map = m;
    q.push_back(t ? c ^ 12'h800 : c);
  endtask

  // ----------------------------------------------------------------
  // Output watcher
  // ----------------------------------------------------------------
  // Sampled mid-cycle, where registered outputs have settled
  always @(negedge core_clk) begin
    if (arst_n) begin
      if (req_ready === 1'b1)
        chk({7'h0, chip_sel_n, sel}, 12'h1f);
      if (chip_sel_n === 1'b0) begin
        // Steps are counted here, so the expectation never trusts bus_addr
        if (!was_low) begin
          held = data_in;
          stp++;
        end
        chk(data_in, held);
        ex_s = exp_sel(cur_map, stp);
        ex_a = (cur_map == MAP_LEFT8 || cur_map == MAP_RIGHT8) ?
               ((stp == 1) ? ADDR_FIRST : ADDR_SECOND) : 2'h0;
        chk({8'h0, sel}, {8'h0, ex_s});
        chk({10'h0, bus_addr}, {10'h0, ex_a});
        if (cur_map == MAP_LEFT8 || cur_map == MAP_RIGHT8)
          chk({8'h0, data_in[11:8]}, 12'h000);
        if (sec_n === 1'b1)
          chk(dac, last);
      end
      was_low = (chip_sel_n === 1'b0);
      if (req_done === 1'b1 && clk_en) begin
        ex = (q.size() > 0) ? q.pop_front() : ~last;
        last = ex;
        stp = 0;
        chk(dac, ex);
      end
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    was_low = 1'b0;
    last = 12'hxxx;
    void'($urandom(32'h777d));
    repeat (8) @(posedge core_clk);
    #1;
    arst_n = 1'b1;
    for (int m = 0; m < 4; m++) begin
      send(dbl_map_t'(m), 12'h000, 1'b0);
      send(dbl_map_t'(m), 12'hfff, 1'b0);
      send(dbl_map_t'(m), 12'h800, 1'b0);
      send(dbl_map_t'(m), 12'h000, 1'b1);
      repeat (6) send(dbl_map_t'(m), 12'($urandom), 1'($urandom));
      $display("test map %0d done", m);
    end
    // Drop the request so the last word is not taken a second time
    req_valid = 1'b0;
    for (int n = 0; n < 4000 && q.size() > 0; n++)
      @(posedge core_clk);
    if (q.size() > 0)
      fails++;
    end_of_test();
  end
endmodule
